/* duart_host_bus_control.sv */
// host bus control of a dual serial controller: register select decode,
// data bus drive, transfer acknowledge and interrupt negation by host access
// assumes the rest of the chip runs on REF_CLK_I and answers reads
// combinationally from REG_ADDR_O while REG_RD_O is high

`include "duart_host_bus_control_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// register access, in clock edges after chip select falls at the pin:
//   edges 1 and 2   pin synchroniser
//   edge 3          address and direction taken, side effects applied
//   edge 4          acknowledge low, read data driven
// after chip select rises again:
//   edge 3          acknowledge driven high, data released
//   edge 4          acknowledge floated
// a vector cycle with an enabled interrupt pending skips the lookup cycle and acknowledges at edge 3; with none pending it is not acknowledged
// the two synchroniser edges are latency traded for immunity to a select
// that lands close to the clock edge
module duart_host_bus_control
   import duart_host_bus_control_pkg::*;
(
   input  wire logic       REF_CLK_I,
   input  wire logic       SRST_I,
   // host bus pins, asynchronous to REF_CLK_I
   input  wire logic       CHIP_SEL_N_I,
   input  wire logic       IRQ_ACK_IN_N_I,
   input  wire logic       READ_WRITE_DIR_I,
   input  wire logic [3:0] REG_SELECT_LINES_I,
   input  wire logic [7:0] DATA_I,
   output logic      [7:0] DATA_O,
   output logic            DATA_OE_O,
   output logic            XFER_ACK_N_O,
   output logic            XFER_ACK_N_OE_O,
   output logic            IRQ_OUT_N_O,
   output logic            IRQ_OUT_N_OE_O,
   output logic      [4:0] DISCRETE_IRQ_PINS_O,
   output logic      [4:0] DISCRETE_IRQ_PINS_OE_O,
   // configuration: which discrete pins act as interrupt outputs
   input  wire logic [4:0] DISC_IRQ_EN_I,
   // interrupt condition set pulses from the channels, counter and port
   input  wire logic [7:0] EVT_SET_I,
   // access strobes towards the rest of the chip
   output logic            REG_WR_O,
   output logic            REG_RD_O,
   output logic      [3:0] REG_ADDR_O,
   output logic      [7:0] REG_WDATA_O,
   input  wire logic [7:0] RD_DATA_I,
   // status for the rest of the chip
   output logic      [7:0] IRQ_PEND_O,
   output logic      [7:0] IRQ_MASK_O
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   localparam int PIN_W = 15;

   // positions inside the synchronised bundle
   localparam int CS_BIT   = 14;
   localparam int IACK_BIT = 13;
   localparam int RW_BIT   = 12;
   localparam int ADDR_LSB = 8;

   sync_bus_if #(.W(PIN_W)) pins_if ();

   // the whole pin bundle crosses together; address and data are stable
   // long before chip select is seen low, so no skew issue arises
   assign pins_if.raw = {CHIP_SEL_N_I, IRQ_ACK_IN_N_I, READ_WRITE_DIR_I,
                         REG_SELECT_LINES_I, DATA_I};

   pin_sync #(
      .W       (PIN_W),
      .RST_VAL ({3'h7, 4'h0, 8'h00})
   ) u_pin_sync (
      .clk_i (REF_CLK_I),
      .rst_i (SRST_I),
      .bus   (pins_if.sync)
   );

   logic       cs_s;
   logic       iack_s;
   logic       rw_s;
   logic [3:0] addr_s;
   logic [7:0] data_s;

   // unpack the bundle; data sits in the low byte
   assign cs_s   = pins_if.cooked[CS_BIT];
   assign iack_s = pins_if.cooked[IACK_BIT];
   assign rw_s   = pins_if.cooked[RW_BIT];
   assign addr_s = pins_if.cooked[ADDR_LSB +: 4];
   assign data_s = pins_if.cooked[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // state

   localparam ctl_state_s RST_STATE = '{
      st:      ST_IDLE,
      addr:    4'h0,
      rd:      1'b0,
      pend:    `RST_PEND,
      mask:    `RST_MASK,
      vec:     `RST_VEC,
      dout:    8'h00,
      dout_oe: 1'b0,
      ack_n:   1'b1,
      ack_oe:  1'b0,
      irq_n:   1'b1,
      irq_oe:  1'b0,
      disc_n:  5'h1F,
      disc_oe: 5'h00,
      reg_wr:  1'b0,
      reg_rd:  1'b0,
      wdata:   8'h00
   };

   // registered state and its next value
   ctl_state_s s_q;
   ctl_state_s s_d;
   // one-cycle clear requests raised by the access taken this cycle
   logic [7:0] clr;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d        = s_q;
      clr        = 8'h00;
      s_d.reg_wr = 1'b0;
      s_d.reg_rd = 1'b0;

      case (s_q.st)
         // wait for a register cycle or a vector cycle
         ST_IDLE: begin
            if (!cs_s) begin
               s_d.addr = addr_s;
               s_d.rd   = rw_s;
               s_d.st   = ST_LOOKUP;
               if (rw_s) begin
                  s_d.reg_rd = 1'b1;
                  // side effects of reads
                  case (addr_s)
                     `OFS_HOLD_A:  clr[`EVT_RX_A] = 1'b1;
                     `OFS_HOLD_B:  clr[`EVT_RX_B] = 1'b1;
                     `OFS_IPC:     clr[`EVT_IPC]  = 1'b1;
                     `OFS_CT_STOP: clr[`EVT_CT]   = 1'b1;
                     default:      clr = 8'h00;
                  endcase
               end else begin
                  s_d.reg_wr = 1'b1;
                  s_d.wdata  = data_s;
                  // side effects of writes
                  case (addr_s)
                     `OFS_HOLD_A: clr[`EVT_TX_A] = 1'b1;
                     `OFS_HOLD_B: clr[`EVT_TX_B] = 1'b1;
                     `OFS_MASK:   s_d.mask = data_s;
                     `OFS_VEC:    s_d.vec  = data_s;
                     `OFS_CMD_A: begin
                        if (data_s[`CMD_HI:`CMD_LO] == `CMD_RST_BRK) begin
                           clr[`EVT_BRK_A] = 1'b1;
                        end
                     end
                     `OFS_CMD_B: begin
                        if (data_s[`CMD_HI:`CMD_LO] == `CMD_RST_BRK) begin
                           clr[`EVT_BRK_B] = 1'b1;
                        end
                     end
                     default: clr = 8'h00;
                  endcase
               end
            end else if (!iack_s) begin
               // vector only when something enabled is pending
               if (!s_q.irq_n) begin
                  s_d.dout    = s_q.vec;
                  s_d.dout_oe = 1'b1;
                  s_d.ack_n   = 1'b0;
                  s_d.ack_oe  = 1'b1;
                  s_d.st      = ST_ACK;
               end else begin
                  s_d.st = ST_IGNORE;
               end
            end
         end

         // the rest of the chip answers during this cycle
         ST_LOOKUP: begin
            if (s_q.rd) begin
               case (s_q.addr)
                  `OFS_MASK: s_d.dout = s_q.pend;
                  `OFS_VEC:  s_d.dout = s_q.vec;
                  default:   s_d.dout = RD_DATA_I;
               endcase
               s_d.dout_oe = 1'b1;
            end
            // data and acknowledge leave on the same edge
            s_d.ack_n  = 1'b0;
            s_d.ack_oe = 1'b1;
            s_d.st     = ST_ACK;
         end

         // hold until both strobes are high again; a short strobe only
         // delays the release, it cannot cut the acknowledge
         ST_ACK: begin
            if (cs_s && iack_s) begin
               s_d.dout_oe = 1'b0;
               s_d.ack_n   = 1'b1;
               s_d.st      = ST_PARK;
            end
         end

         // one cycle of driven high before letting the line float
         ST_PARK: begin
            s_d.ack_oe = 1'b0;
            s_d.st     = ST_IDLE;
         end

         // unanswered vector cycle, wait for its end
         ST_IGNORE: begin
            if (iack_s) begin
               s_d.st = ST_IDLE;
            end
         end

         default: begin
            s_d = RST_STATE;
         end
      endcase

      // a new event in the clearing cycle survives
      // events arrive as one-cycle pulses, so nothing is lost while idle
      s_d.pend  = (s_q.pend & ~clr) | EVT_SET_I;
      s_d.irq_n = ~|(s_d.pend & s_d.mask);
      s_d.irq_oe = ~s_d.irq_n;

      // discrete pins are pulled low only while their condition is pending
      // pins without enable stay released whatever is pending
      s_d.disc_n[0] = ~(s_d.pend[`DISC_SRC_0] & DISC_IRQ_EN_I[0]);
      s_d.disc_n[1] = ~(s_d.pend[`DISC_SRC_1] & DISC_IRQ_EN_I[1]);
      s_d.disc_n[2] = ~(s_d.pend[`DISC_SRC_2] & DISC_IRQ_EN_I[2]);
      s_d.disc_n[3] = ~(s_d.pend[`DISC_SRC_3] & DISC_IRQ_EN_I[3]);
      s_d.disc_n[4] = ~(s_d.pend[`DISC_SRC_4] & DISC_IRQ_EN_I[4]);
      s_d.disc_oe   = ~s_d.disc_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   // host data bus and acknowledge
   assign DATA_O                 = s_q.dout;
   assign DATA_OE_O              = s_q.dout_oe;
   assign XFER_ACK_N_O           = s_q.ack_n;
   assign XFER_ACK_N_OE_O        = s_q.ack_oe;

   // interrupt line and discrete pins; open drain, so the level only
   // matters while the enable is high
   assign IRQ_OUT_N_O            = s_q.irq_n;   // open drain: low only with oe
   assign IRQ_OUT_N_OE_O         = s_q.irq_oe;
   assign DISCRETE_IRQ_PINS_O    = s_q.disc_n;
   assign DISCRETE_IRQ_PINS_OE_O = s_q.disc_oe;

   // strobes and captured access towards the rest of the chip
   assign REG_WR_O               = s_q.reg_wr;
   assign REG_RD_O               = s_q.reg_rd;
   assign REG_ADDR_O             = s_q.addr;
   assign REG_WDATA_O            = s_q.wdata;

   // status for the rest of the chip
   assign IRQ_PEND_O             = s_q.pend;
   assign IRQ_MASK_O             = s_q.mask;

endmodule : duart_host_bus_control

/* duart_host_bus_control_regs.svh */
// constants of the host bus control block: register offsets, event bit
// positions, command codes and reset values
// assumes inclusion by bare name from the package, the top module and the
// verification files; the guard keeps repeated inclusion harmless
`ifndef DUART_HOST_BUS_CONTROL_REGS_SVH
`define DUART_HOST_BUS_CONTROL_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets on the four select lines
`define OFS_CMD_A      4'h2
`define OFS_HOLD_A     4'h3
`define OFS_IPC        4'h4
`define OFS_MASK       4'h5
`define OFS_CMD_B      4'hA
`define OFS_HOLD_B     4'hB
`define OFS_VEC        4'hC
`define OFS_CT_STOP    4'hF

////////////////////////////////////////////////////////////////////////////////
// positions of the eight interrupt conditions in the pending and mask bytes
`define EVT_TX_A       0
`define EVT_RX_A       1
`define EVT_BRK_A      2
`define EVT_CT         3
`define EVT_TX_B       4
`define EVT_RX_B       5
`define EVT_BRK_B      6
`define EVT_IPC        7

// condition carried by each discrete interrupt pin, pin 0 first
`define DISC_SRC_0     `EVT_CT
`define DISC_SRC_1     `EVT_RX_A
`define DISC_SRC_2     `EVT_RX_B
`define DISC_SRC_3     `EVT_TX_A
`define DISC_SRC_4     `EVT_TX_B

////////////////////////////////////////////////////////////////////////////////
// command field of a command register write
`define CMD_HI         7
`define CMD_LO         4
`define CMD_RST_BRK    4'h5

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_MASK       8'h00
`define RST_VEC        8'h0F
`define RST_PEND       8'h00

`endif

/* duart_host_bus_control_pkg.sv */
// types shared by the host bus control block
// assumes the constants header sits in the same folder
package duart_host_bus_control_pkg;
`include "duart_host_bus_control_regs.svh"

   // bus cycle sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOOKUP,
      ST_ACK,
      ST_PARK,
      ST_IGNORE
   } ctl_state_e;

   // whole state of the top module
   typedef struct packed {
      ctl_state_e st;
      logic [3:0] addr;
      logic       rd;
      logic [7:0] pend;
      logic [7:0] mask;
      logic [7:0] vec;
      logic [7:0] dout;
      logic       dout_oe;
      logic       ack_n;
      logic       ack_oe;
      logic       irq_n;
      logic       irq_oe;
      logic [4:0] disc_n;
      logic [4:0] disc_oe;
      logic       reg_wr;
      logic       reg_rd;
      logic [7:0] wdata;
   } ctl_state_s;

endpackage : duart_host_bus_control_pkg

/* sync_bus_if.sv */
// carrier between the top module and its pin synchroniser
// assumes both ends run on the same clock
interface sync_bus_if #(
   parameter int W = 1
);
   logic [W-1:0] raw;
   logic [W-1:0] cooked;

   modport feed (output raw, input cooked);
   modport sync (input raw, output cooked);
endinterface : sync_bus_if

/* pin_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous pins
// assumes a synchronous active-high reset on the same clock
module pin_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   sync_bus_if.sync    bus
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] safe;
   } sync_state_s;

   sync_state_s s_q;
   sync_state_s s_d;

   // first stage feeds only the second stage
   always_comb begin
      s_d      = s_q;
      s_d.meta = bus.raw;
      s_d.safe = s_q.meta;
   end

   // reset to the idle level of the pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{meta: RST_VAL, safe: RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.cooked = s_q.safe;
endmodule : pin_sync

/* duart_host_bus_control_assertions.sv */
// checker of the host bus control block: handshake, data drive and interrupts
// assumes the constants header sits in the same folder
`include "duart_host_bus_control_regs.svh"

module duart_host_bus_control_assertions (
   input wire logic       REF_CLK_I,
   input wire logic       SRST_I,
   input wire logic       CHIP_SEL_N_I,
   input wire logic       READ_WRITE_DIR_I,
   input wire logic       XFER_ACK_N_O,
   input wire logic       XFER_ACK_N_OE_O,
   input wire logic       DATA_OE_O,
   input wire logic       IRQ_OUT_N_O,
   input wire logic       IRQ_OUT_N_OE_O,
   input wire logic [4:0] DISC_IRQ_EN_I,
   input wire logic [4:0] DISCRETE_IRQ_PINS_OE_O,
   input wire logic [7:0] EVT_SET_I,
   input wire logic [7:0] IRQ_PEND_O,
   input wire logic [7:0] IRQ_MASK_O,
   input wire logic       REG_RD_O,
   input wire logic       REG_WR_O,
   input wire logic [3:0] REG_ADDR_O,
   input wire logic [7:0] REG_WDATA_O
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);

   ////////////////////////////////////////////////////////////////////////////
   // handshake: late setup may cost one clock, so the window is a range
   a_ack_timely: assert property ($fell(CHIP_SEL_N_I) |-> ##[3:6] !XFER_ACK_N_O)
      else $error("acknowledge late after select");
   a_ack_stands: assert property (!XFER_ACK_N_O && !CHIP_SEL_N_I |=> !XFER_ACK_N_O)
      else $error("acknowledge dropped while selected");
   a_ack_driven: assert property (!XFER_ACK_N_O |-> XFER_ACK_N_OE_O)
      else $error("acknowledge low but not driven");
   a_ack_release: assert property ($rose(CHIP_SEL_N_I) && !XFER_ACK_N_O |->
      ##[1:4] (XFER_ACK_N_O && XFER_ACK_N_OE_O && !DATA_OE_O) ##1 !XFER_ACK_N_OE_O)
      else $error("acknowledge not released properly");
   a_data_with_ack: assert property (DATA_OE_O |-> !XFER_ACK_N_O && XFER_ACK_N_OE_O)
      else $error("data driven outside acknowledge");
   a_write_no_drive: assert property (!CHIP_SEL_N_I && !READ_WRITE_DIR_I |-> !DATA_OE_O)
      else $error("data driven in write cycle");

   ////////////////////////////////////////////////////////////////////////////
   // interrupt line, pending bits and negation by host accesses
   a_irq_line: assert property (IRQ_OUT_N_OE_O == (|(IRQ_PEND_O & IRQ_MASK_O))
      && IRQ_OUT_N_O == !IRQ_OUT_N_OE_O)
      else $error("interrupt line disagrees with pending and mask");
   a_pend_set: assert property (|EVT_SET_I |=> (IRQ_PEND_O & $past(EVT_SET_I)) == $past(EVT_SET_I))
      else $error("pending bit not set by event");
   a_disc_follow: assert property (DISC_IRQ_EN_I == $past(DISC_IRQ_EN_I)
      && DISC_IRQ_EN_I == $past(DISC_IRQ_EN_I, 2) |-> DISCRETE_IRQ_PINS_OE_O == (DISC_IRQ_EN_I
      & {IRQ_PEND_O[`EVT_TX_B], IRQ_PEND_O[`EVT_TX_A], IRQ_PEND_O[`EVT_RX_B],
      IRQ_PEND_O[`EVT_RX_A], IRQ_PEND_O[`EVT_CT]}))
      else $error("discrete pin disagrees with its condition");
   a_rx_read_clear: assert property (REG_RD_O && REG_ADDR_O == `OFS_HOLD_A |->
      !IRQ_PEND_O[`EVT_RX_A] || $past(EVT_SET_I[`EVT_RX_A]))
      else $error("receiver interrupt kept after holding read");
   a_tx_write_clear: assert property (REG_WR_O && REG_ADDR_O == `OFS_HOLD_A |->
      !IRQ_PEND_O[`EVT_TX_A] || $past(EVT_SET_I[`EVT_TX_A]))
      else $error("transmitter interrupt kept after holding write");
   a_mask_write: assert property (REG_WR_O && REG_ADDR_O == `OFS_MASK |->
      IRQ_MASK_O == REG_WDATA_O)
      else $error("mask not taken from write");
endmodule : duart_host_bus_control_assertions

bind duart_host_bus_control duart_host_bus_control_assertions i_duart_host_bus_control_assertions (
   .REF_CLK_I, .SRST_I, .CHIP_SEL_N_I, .READ_WRITE_DIR_I, .XFER_ACK_N_O, .XFER_ACK_N_OE_O,
   .DATA_OE_O, .IRQ_OUT_N_O, .IRQ_OUT_N_OE_O, .DISC_IRQ_EN_I, .DISCRETE_IRQ_PINS_OE_O,
   .EVT_SET_I, .IRQ_PEND_O, .IRQ_MASK_O, .REG_RD_O, .REG_WR_O, .REG_ADDR_O, .REG_WDATA_O);

/* host_cpu_model.sv */
// model of the host processor on the acknowledge handshake bus
// assumes it shares the block clock and drives its pins at falling edges
module host_cpu_model (
   input  wire logic       clk_i,
   input  wire logic       ack_n_i,
   input  wire logic       ack_oe_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rdata_oe_i,
   output logic            cs_n_o,
   output logic            iack_n_o,
   output logic            rw_o,
   output logic      [3:0] addr_o,
   output logic      [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus; write data lines show a toggling value when not in use
   initial begin
      cs_n_o   = 1'b1;
      iack_n_o = 1'b1;
      rw_o     = 1'b1;
      addr_o   = 4'h0;
      wdata_o  = 8'h5A;
   end

   // one bus cycle; strobe held until acknowledge is seen, bounded wait
   task automatic xfer(input logic vec, input logic rd, input logic [3:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic ok);
      ok = 1'b0;
      q = 8'h00;
      @(negedge clk_i);
      rw_o    <= rd;
      addr_o  <= a;
      wdata_o <= rd ? ~wdata_o : d;
      if (vec) begin
         iack_n_o <= 1'b0;
      end else begin
         cs_n_o <= 1'b0;
      end
      for (int n = 0; n < 12 && !ok; n++) begin
         @(posedge clk_i);
         if (ack_oe_i === 1'b1 && ack_n_i === 1'b0) begin
            ok = 1'b1;
            q = rdata_oe_i ? rdata_i : 'x;
         end
      end
      @(negedge clk_i);
      cs_n_o   <= 1'b1;
      iack_n_o <= 1'b1;
      wdata_o  <= ~wdata_o;
      for (int n = 0; n < 10 && ack_oe_i !== 1'b0; n++) @(posedge clk_i);
      // spacing also covers back-to-back command register writes
      repeat (3) @(posedge clk_i);
   endtask : xfer
endmodule : host_cpu_model

/* tb_duart_host_bus_control.sv */
// self-checking bench of the host bus control block
// assumes the design, the checker and the host model are compiled before it
`include "duart_host_bus_control_regs.svh"

module tb_duart_host_bus_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, srst, cs_n, iack_n, rw, dout_oe, ack_n, ack_oe, irq_n, irq_oe, reg_wr, reg_rd;
   logic [3:0] sel, reg_addr;
   logic [4:0] disc, disc_oe, disc_en;
   logic [7:0] wdata, dout, evt, rdd, pend, mask, reg_wdata;
   int         n_errors = 0, checks_done = 0, cycles = 0;
   int         n_rd = 0, n_wr = 0;

   // rest of the chip answers reads with a pattern built from the offset
   assign rdd = {4'hC, reg_addr};

   duart_host_bus_control i_duart_host_bus_control (
      .REF_CLK_I(ref_clk), .SRST_I(srst), .CHIP_SEL_N_I(cs_n), .IRQ_ACK_IN_N_I(iack_n),
      .READ_WRITE_DIR_I(rw), .REG_SELECT_LINES_I(sel), .DATA_I(wdata), .DATA_O(dout),
      .DATA_OE_O(dout_oe), .XFER_ACK_N_O(ack_n), .XFER_ACK_N_OE_O(ack_oe),
      .IRQ_OUT_N_O(irq_n), .IRQ_OUT_N_OE_O(irq_oe), .DISCRETE_IRQ_PINS_O(disc),
      .DISCRETE_IRQ_PINS_OE_O(disc_oe), .DISC_IRQ_EN_I(disc_en), .EVT_SET_I(evt),
      .REG_WR_O(reg_wr), .REG_RD_O(reg_rd), .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata),
      .RD_DATA_I(rdd), .IRQ_PEND_O(pend), .IRQ_MASK_O(mask));

   host_cpu_model i_host_cpu_model (
      .clk_i(ref_clk), .ack_n_i(ack_n), .ack_oe_i(ack_oe), .rdata_i(dout),
      .rdata_oe_i(dout_oe), .cs_n_o(cs_n), .iack_n_o(iack_n), .rw_o(rw), .addr_o(sel),
      .wdata_o(wdata));

   ////////////////////////////////////////////////////////////////////////////
   // clock, and a cycle ceiling well above the roughly 350 cycles needed
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         complete_run();
      end
   end

   // count access strobes towards the rest of the chip
   always @(posedge ref_clk) begin
      if (reg_rd === 1'b1) n_rd++;
      if (reg_wr === 1'b1) n_wr++;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   ////////////////////////////////////////////////////////////////////////////
   // shared bus cycle and event pulse
   task automatic bus(input logic vec, input logic rd, input logic [3:0] a,
                      input logic [7:0] d, input logic [7:0] exp, input logic ack);
      logic [7:0] q;
      logic       ok;
      i_host_cpu_model.xfer(vec, rd, a, d, q, ok);
      // later checks and input changes happen away from the rising edge
      @(negedge ref_clk);
      check_val("acknowledge", {7'h00, ack}, {7'h00, ok});
      if (rd && ack) check_val("read data", exp, q);
   endtask : bus

   task automatic pulse(input int b);
      @(negedge ref_clk);
      evt = 8'h01 << b;
      @(negedge ref_clk);
      evt = 8'h00;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_plain_access();
      logic [3:0] offs [4] = '{4'h0, 4'h1, 4'hD, 4'hE};
      foreach (offs[i]) bus(1'b0, 1'b1, offs[i], 8'h00, {4'hC, offs[i]}, 1'b1);
      check_val("read strobes", 8'h04, n_rd[7:0]);
      bus(1'b0, 1'b0, `OFS_CMD_A, 8'h10, 8'h00, 1'b1);
      bus(1'b0, 1'b0, `OFS_CMD_A, 8'h20, 8'h00, 1'b1);
      check_val("write strobes", 8'h02, n_wr[7:0]);
      check_val("access address", {4'h0, `OFS_CMD_A}, {4'h0, reg_addr});
      check_val("write data", 8'h20, reg_wdata);
   endtask : t_plain_access

   task automatic t_vector();
      bus(1'b1, 1'b1, 4'h0, 8'h00, 8'h00, 1'b0);
      bus(1'b0, 1'b0, `OFS_MASK, 8'hFF, 8'h00, 1'b1);
      pulse(`EVT_RX_A);
      check_val("interrupt line", 8'h00, {7'h00, irq_n});
      check_val("interrupt drive", 8'h01, {7'h00, irq_oe});
      bus(1'b1, 1'b1, 4'h0, 8'h00, `RST_VEC, 1'b1);
      bus(1'b0, 1'b0, `OFS_VEC, 8'h42, 8'h00, 1'b1);
      bus(1'b1, 1'b1, 4'h0, 8'h00, 8'h42, 1'b1);
      bus(1'b0, 1'b1, `OFS_HOLD_A, 8'h00, {4'hC, `OFS_HOLD_A}, 1'b1);
      check_val("interrupt line", 8'h01, {7'h00, irq_n});
      check_val("interrupt drive", 8'h00, {7'h00, irq_oe});
   endtask : t_vector

   // every condition in turn, cleared by its own access; odd bits clear on reads
   task automatic t_clears();
      logic [3:0] offs [8] = '{`OFS_HOLD_A, `OFS_HOLD_A, `OFS_CMD_A, `OFS_CT_STOP,
                               `OFS_HOLD_B, `OFS_HOLD_B, `OFS_CMD_B, `OFS_IPC};
      logic [4:0] dexp [8] = '{5'h08, 5'h02, 5'h00, 5'h01, 5'h10, 5'h04, 5'h00, 5'h00};
      disc_en = 5'h1F;
      for (int b = 0; b < 8; b++) begin
         pulse(b);
         check_val("pending", 8'h01 << b, pend);
         check_val("interrupt line", 8'h00, {7'h00, irq_n});
         check_val("discrete", {3'h0, dexp[b]}, {3'h0, disc_oe});
         check_val("discrete level", {3'h0, ~dexp[b]}, {3'h0, disc});
         bus(1'b0, b[0], offs[b], 8'h50, {4'hC, offs[b]}, 1'b1);
         check_val("pending", 8'h00, pend);
         check_val("discrete", 8'h00, {3'h0, disc_oe});
         check_val("discrete level", 8'h1F, {3'h0, disc});
         check_val("interrupt line", 8'h01, {7'h00, irq_n});
      end
   endtask : t_clears

   task automatic t_mask_clear();
      disc_en = 5'h00;
      pulse(`EVT_RX_A);
      check_val("discrete", 8'h00, {3'h0, disc_oe});
      bus(1'b0, 1'b0, `OFS_MASK, 8'hFD, 8'h00, 1'b1);
      check_val("mask", 8'hFD, mask);
      check_val("interrupt line", 8'h01, {7'h00, irq_n});
      bus(1'b0, 1'b1, `OFS_MASK, 8'h00, 8'h02, 1'b1);
      bus(1'b0, 1'b1, `OFS_HOLD_A, 8'h00, {4'hC, `OFS_HOLD_A}, 1'b1);
      check_val("pending", 8'h00, pend);
   endtask : t_mask_clear

   // main sequence: reset for three cycles, then the scenarios
   initial begin
      srst = 1'b1;
      disc_en = 5'h00;
      evt = 8'h00;
      repeat (3) @(negedge ref_clk);
      srst = 1'b0;
      check_val("mask", `RST_MASK, mask);
      check_val("pending", `RST_PEND, pend);
      t_plain_access();
      t_vector();
      t_clears();
      t_mask_clear();
      complete_run();
   end
endmodule : tb_duart_host_bus_control
